// ==== design/bus_pin_pkg.sv ====
// Package: constants and types for the external bus pin logic
package bus_pin_pkg;

	localparam int addr_w = 32;
	localparam int data_w = 64;
	localparam int lanes = 8;
	localparam int wrap_bit = 20;
	localparam int addr_lo = 3;
	localparam int snoop_lo = 5;
	localparam int id_w = 4;
	localparam int ratio_w = 2;
	localparam int brk_w = 4;
	localparam int sel_w = 2;
	localparam logic [sel_w-1:0] sel_reset = 2'h0; // Perf monitor after reset
	localparam logic [lanes-1:0] lanes_none_n = 8'hff;
	localparam logic [id_w-1:0] id_reset = 4'h0;
	localparam logic [ratio_w-1:0] ratio_reset = 2'h0;

	// Bus cycle phase; Gray codes along idle -> addr -> data -> back
	typedef enum logic [1:0] {
		ph_idle = 2'b00,
		ph_addr = 2'b01,
		ph_data = 2'b11,
		ph_back = 2'b10
	} phase_type;

	// One bus request from the core
	typedef struct packed {
		logic [addr_w-1:addr_lo] addr;
		logic [lanes-1:0] lane_n;
		logic write;
		logic data_cyc;
		logic cacheable;
		logic [data_w-1:0] wdata;
	} req_type;

	// Reset-captured straps
	typedef struct packed {
		logic intc_en;
		logic [id_w-1:0] intc_id;
		logic [ratio_w-1:0] ratio;
		logic secondary;
	} strap_type;

	// Machine-check capture
	typedef struct packed {
		logic [addr_w-1:addr_lo] addr;
		logic write;
		logic data_cyc;
	} mchk_type;

endpackage : bus_pin_pkg

// ==== design/bus_pin_logic.sv ====
// Design: processor-side external bus pin logic
`timescale 1ns/1ps

module bus_pin_logic (
	input wire logic clk,
	input wire logic rst_n,
	// Core side
	input wire logic req_valid,
	input wire bus_pin_pkg::req_type req,
	output logic req_done,
	output logic [bus_pin_pkg::data_w-1:0] rd_data,
	output logic rd_cache,
	output logic rd_parity_err,
	input wire logic [bus_pin_pkg::brk_w-1:0] debug_match_regs,
	input wire logic [bus_pin_pkg::sel_w-1:0] func_sel_in,
	input wire logic func_sel_we,
	input wire logic [bus_pin_pkg::sel_w-1:0] perfmon_evt,
	input wire logic mchk_exc_enable,
	output logic mchk_exc,
	output bus_pin_pkg::mchk_type mchk_info,
	output bus_pin_pkg::strap_type straps,
	// Pins
	input wire logic addr_wrap_mask_n,
	input wire logic addr_float_req,
	input wire logic bus_abort_n,
	input wire logic xfer_done_n,
	input wire logic xfer_done_dup_n,
	input wire logic cycle_fail_n,
	input wire logic ext_cache_allow_n,
	input wire logic snoop_addr_strobe_n,
	input wire logic proc_role_strap,
	input wire logic [bus_pin_pkg::ratio_w-1:0] bus_core_ratio,
	input wire logic intc_bus_data1,
	input wire logic [bus_pin_pkg::addr_w-1:bus_pin_pkg::addr_lo] addr_in,
	output logic [bus_pin_pkg::addr_w-1:bus_pin_pkg::addr_lo] addr_out,
	output logic addr_oe,
	input wire logic addr_parity_in,
	output logic addr_parity_out,
	output logic addr_parity_oe,
	output logic addr_parity_err_n,
	input wire logic [bus_pin_pkg::lanes-1:0] byte_lane_sel_in_n,
	output logic [bus_pin_pkg::lanes-1:0] byte_lane_sel_n,
	output logic byte_lane_oe,
	input wire logic [bus_pin_pkg::data_w-1:0] data_in,
	output logic [bus_pin_pkg::data_w-1:0] data_out,
	output logic data_oe,
	input wire logic [bus_pin_pkg::lanes-1:0] byte_parity_in,
	output logic [bus_pin_pkg::lanes-1:0] byte_parity_out,
	output logic cycle_strobe_n,
	output logic cycle_strobe_dup_n,
	output logic data_code,
	output logic cache_out_n,
	output logic owner_n,
	output logic bus_want,
	output logic [bus_pin_pkg::brk_w-1:0] brkpt_match,
	output logic [bus_pin_pkg::sel_w-1:0] perfmon_brkpt_shared
);

	// -------------------------------------------------------------
	// State
	// -------------------------------------------------------------
	typedef struct packed {
		bus_pin_pkg::phase_type ph;
		bus_pin_pkg::req_type cur;
		logic rst_seen;
		bus_pin_pkg::strap_type straps;
		logic [bus_pin_pkg::sel_w-1:0] sel;
		logic abort;
		logic hold;
		logic [1:0] snoop_pipe;
		logic snoop_perr;
		logic par_err_n;
		logic [bus_pin_pkg::addr_w-1:bus_pin_pkg::addr_lo] addr;
		logic addr_oe;
		logic ap;
		logic [bus_pin_pkg::lanes-1:0] lane_n;
		logic lane_oe;
		logic [bus_pin_pkg::data_w-1:0] dout;
		logic [bus_pin_pkg::lanes-1:0] dpar;
		logic doe;
		logic ads_n;
		logic dc;
		logic cache_n;
		logic own_n;
		logic want;
		logic [bus_pin_pkg::brk_w-1:0] brk;
		logic [bus_pin_pkg::sel_w-1:0] pm;
		logic done;
		logic [bus_pin_pkg::data_w-1:0] rdata;
		logic rcache;
		logic rperr;
		logic mexc;
		bus_pin_pkg::mchk_type minfo;
	} state_type;

	state_type s_q;
	state_type s_d;

	// Even parity per byte lane
	function automatic logic [bus_pin_pkg::lanes-1:0] lane_par(
		input logic [bus_pin_pkg::data_w-1:0] d);
		logic [bus_pin_pkg::lanes-1:0] p;
		p = '0;
		for (int i = 0; i < bus_pin_pkg::lanes; i++) begin
			p[i] = ^d[i*8 +: 8];
		end
		return p;
	endfunction : lane_par

	logic wrap_on;
	logic done_in;
	logic snoop_par_bad;
	logic [bus_pin_pkg::addr_w-1:bus_pin_pkg::addr_lo] masked_addr;

	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// Secondary role masks the wrap input internally
		wrap_on = !addr_wrap_mask_n && !s_q.straps.secondary;
		masked_addr = s_d.cur.addr;
		done_in = !xfer_done_n || !xfer_done_dup_n;
		snoop_par_bad = (^addr_in[bus_pin_pkg::addr_w-1:bus_pin_pkg::snoop_lo])
			^ addr_parity_in;
		s_d.done = 1'b0;
		s_d.rperr = 1'b0;
		s_d.mexc = 1'b0;
		s_d.ads_n = 1'b1;
		s_d.want = req_valid || s_q.ph != bus_pin_pkg::ph_idle;

		// Straps caught on the first clock after reset release
		if (!s_q.rst_seen) begin
			s_d.rst_seen = 1'b1;
			s_d.straps.intc_en = intc_bus_data1;
			s_d.straps.intc_id =
				byte_lane_sel_in_n[bus_pin_pkg::id_w-1:0];
			s_d.straps.ratio = bus_core_ratio;
			s_d.straps.secondary = proc_role_strap;
		end

		// Debug mode control bits select the shared pins
		if (func_sel_we) begin
			s_d.sel = func_sel_in;
		end
		s_d.brk = debug_match_regs;
		for (int i = 0; i < bus_pin_pkg::sel_w; i++) begin
			s_d.pm[i] = s_q.sel[i] ? debug_match_regs[i]
				: perfmon_evt[i];
		end

		// Snoop parity check one clock after the strobe is sampled
		s_d.snoop_pipe = {s_q.snoop_pipe[0], !snoop_addr_strobe_n};
		if (!snoop_addr_strobe_n) begin
			s_d.snoop_perr = snoop_par_bad;
		end
		s_d.par_err_n = !(s_q.snoop_pipe[0] && s_q.snoop_perr);

		// Address hold floats address and parity next clock
		s_d.hold = addr_float_req;
		s_d.abort = !bus_abort_n;

		// Bus cycle sequencing
		unique case (s_q.ph)
			bus_pin_pkg::ph_idle: begin
				if (req_valid && bus_abort_n) begin
					s_d.cur = req;
					s_d.ph = bus_pin_pkg::ph_addr;
				end
			end
			bus_pin_pkg::ph_addr: begin
				s_d.ph = bus_pin_pkg::ph_data;
			end
			bus_pin_pkg::ph_data: begin
				if (done_in) begin
					s_d.done = 1'b1;
					s_d.ph = bus_pin_pkg::ph_idle;
					if (!s_q.cur.write) begin
						s_d.rdata = data_in;
						s_d.rperr = lane_par(data_in) != byte_parity_in;
						// Uncacheable request is never cached
						s_d.rcache = s_q.cur.cacheable
							&& !ext_cache_allow_n;
					end
				end
			end
			bus_pin_pkg::ph_back: begin
				if (bus_abort_n) begin
					s_d.ph = bus_pin_pkg::ph_addr;
				end
			end
		endcase
		// Abort kills the cycle in flight; it reruns from the start
		if (!bus_abort_n && s_q.ph != bus_pin_pkg::ph_idle) begin
			s_d.ph = bus_pin_pkg::ph_back;
			s_d.done = 1'b0;
		end

		// Cycle fail capture
		if (!cycle_fail_n) begin
			s_d.minfo.addr = s_q.cur.addr;
			s_d.minfo.write = s_q.cur.write;
			s_d.minfo.data_cyc = s_q.cur.data_cyc;
			s_d.mexc = mchk_exc_enable;
		end

		// Drive address group when the cycle starts
		if (s_d.ph == bus_pin_pkg::ph_addr) begin
			masked_addr = s_d.cur.addr;
			if (wrap_on) begin
				masked_addr[bus_pin_pkg::wrap_bit] = 1'b0;
			end
			s_d.addr = masked_addr;
			s_d.ap = ^masked_addr;
			s_d.lane_n = s_d.cur.lane_n;
			s_d.ads_n = 1'b0;
			s_d.dc = s_d.cur.data_cyc;
			s_d.cache_n = !s_d.cur.cacheable;
		end
		s_d.addr_oe = s_d.ph != bus_pin_pkg::ph_idle
			&& s_d.ph != bus_pin_pkg::ph_back && !addr_float_req;
		s_d.lane_oe = s_d.ph != bus_pin_pkg::ph_idle
			&& s_d.ph != bus_pin_pkg::ph_back;
		// Write data in the data phase with lane parity
		s_d.doe = s_d.ph == bus_pin_pkg::ph_data && s_d.cur.write;
		s_d.dout = s_d.cur.wdata;
		s_d.dpar = lane_par(s_d.cur.wdata);
		// Primary shows ownership; secondary leaves it high
		s_d.own_n = !(s_d.lane_oe && !s_q.straps.secondary);
	end

	// -------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.ph <= bus_pin_pkg::ph_idle;
			s_q.straps.intc_id <= bus_pin_pkg::id_reset;
			s_q.straps.ratio <= bus_pin_pkg::ratio_reset;
			s_q.sel <= bus_pin_pkg::sel_reset;
			s_q.par_err_n <= 1'b1;
			s_q.lane_n <= bus_pin_pkg::lanes_none_n;
			s_q.ads_n <= 1'b1;
			s_q.cache_n <= 1'b1;
			s_q.own_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// -------------------------------------------------------------
	// Outputs straight from flip-flops
	// -------------------------------------------------------------
	assign req_done = s_q.done;
	assign rd_data = s_q.rdata;
	assign rd_cache = s_q.rcache;
	assign rd_parity_err = s_q.rperr;
	assign mchk_exc = s_q.mexc;
	assign mchk_info = s_q.minfo;
	assign straps = s_q.straps;
	assign addr_out = s_q.addr;
	assign addr_oe = s_q.addr_oe;
	assign addr_parity_out = s_q.ap;
	assign addr_parity_oe = s_q.addr_oe;
	assign addr_parity_err_n = s_q.par_err_n;
	assign byte_lane_sel_n = s_q.lane_n;
	assign byte_lane_oe = s_q.lane_oe;
	assign data_out = s_q.dout;
	assign data_oe = s_q.doe;
	assign byte_parity_out = s_q.dpar;
	assign cycle_strobe_n = s_q.ads_n;
	assign cycle_strobe_dup_n = s_q.ads_n;
	assign data_code = s_q.dc;
	assign cache_out_n = s_q.cache_n;
	assign owner_n = s_q.own_n;
	assign bus_want = s_q.want;
	assign brkpt_match = s_q.brk;
	assign perfmon_brkpt_shared = s_q.pm;

endmodule : bus_pin_logic

// ==== test/bus_pin_logic_sva.sv ====
// Checker: port timing relations of the external bus pin logic
`timescale 1ns/1ps
module bus_pin_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cycle_strobe_n,
	input wire logic [31:3] addr_out,
	input wire logic addr_parity_out,
	input wire logic addr_oe,
	input wire logic addr_parity_oe,
	input wire logic addr_float_req,
	input wire logic bus_abort_n,
	input wire logic data_oe,
	input wire logic [63:0] data_out,
	input wire logic [7:0] byte_parity_out,
	input wire logic snoop_addr_strobe_n,
	input wire logic [31:3] addr_in,
	input wire logic addr_parity_in,
	input wire logic addr_parity_err_n,
	input wire logic cycle_fail_n,
	input wire logic mchk_exc_enable,
	input wire logic mchk_exc,
	input wire logic addr_wrap_mask_n,
	input wire logic owner_n,
	input wire bus_pin_pkg::strap_type straps
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Even parity per lane, bit i covers byte i
	function automatic logic [7:0] lane_par(logic [63:0] d);
		for (int i = 0; i < 8; i++)
			lane_par[i] = ^d[8*i+:8];
	endfunction : lane_par
	// Relations at the launch of an originated cycle and while write data is driven
	addr_par_a: assert property (!cycle_strobe_n |->
		addr_parity_out == ^addr_out) else $error("address parity odd");
	wrap_mask_a: assert property (!cycle_strobe_n &&
		!straps.secondary && $past(!addr_wrap_mask_n) |-> !addr_out[20])
		else $error("bit 20 not masked");
	owner_ind_a: assert property (!cycle_strobe_n |->
		owner_n == straps.secondary) else $error("owner flag wrong");
	lane_par_a: assert property (data_oe |->
		byte_parity_out == lane_par(data_out)) else $error("lane parity");
	// Bus release on hold and abort, one clock later
	hold_float_a: assert property (addr_float_req |=>
		!addr_oe && !addr_parity_oe) else $error("address not floated");
	abort_float_a: assert property (!bus_abort_n |=>
		!addr_oe && !data_oe) else $error("bus not floated on abort");
	// Snoop check two clocks on, and machine check one clock on
	snoop_err_a: assert property (!snoop_addr_strobe_n &&
		(^addr_in[31:5] != addr_parity_in) |-> ##2 !addr_parity_err_n)
		else $error("snoop parity error missed");
	mchk_exc_a: assert property (!cycle_fail_n |=>
		mchk_exc == $past(mchk_exc_enable)) else $error("exception wrong");
	cover property (!addr_parity_err_n);
	cover property (!bus_abort_n ##1 !addr_oe);
	cover property (mchk_exc);
endmodule : bus_pin_sva
bind bus_pin_logic bus_pin_sva chk_u (.*);

// ==== test/bus_partner.sv ====
// Far-side model: chipset answering cycles the block originates
`timescale 1ns/1ps
module bus_partner (
	input wire logic clk,
	input wire logic cycle_strobe_n,
	input wire logic [3:0] lat,
	input wire logic bad_par,
	input wire logic [63:0] rdata,
	input wire logic dup,
	output logic xfer_done_n,
	output logic xfer_done_dup_n,
	output logic [63:0] data_in,
	output logic [7:0] byte_parity_in
);
	int cnt = -1;
	logic seen;
	initial begin
		xfer_done_n = 1'b1;
		xfer_done_dup_n = 1'b1;
		data_in = 64'h0;
		byte_parity_in = 8'h0;
	end
	// Answer lat clocks after a strobe; a reissued strobe restarts it
	always @(posedge clk) begin
		seen = !cycle_strobe_n;
		#1;
		xfer_done_n = 1'b1;
		xfer_done_dup_n = 1'b1;
		// Released lines toggle so stale data cannot pass
		data_in = ~data_in;
		byte_parity_in = ~byte_parity_in;
		if (seen)
			cnt = lat;
		else if (cnt > 0)
			cnt--;
		if (cnt == 0) begin
			cnt = -1;
			// Either ready pin may carry the answer
			if (dup)
				xfer_done_dup_n = 1'b0;
			else
				xfer_done_n = 1'b0;
			data_in = rdata;
			for (int i = 0; i < 8; i++)
				byte_parity_in[i] = ^rdata[8*i+:8] ^ (bad_par && i == 0);
		end
	end
endmodule : bus_partner

// ==== test/bus_pin_logic_bench.sv ====
// Testbench: directed scenarios for the external bus pin logic
`timescale 1ns/1ps
module bus_pin_logic_bench;
	logic clk, rst_n, req_valid, req_done, rd_cache, rd_parity_err;
	logic func_sel_we, mchk_exc_enable, mchk_exc, addr_wrap_mask_n;
	logic addr_float_req, bus_abort_n, xfer_done_n, xfer_done_dup_n;
	logic cycle_fail_n, ext_cache_allow_n, snoop_addr_strobe_n;
	logic proc_role_strap, intc_bus_data1, addr_oe, addr_parity_in;
	logic addr_parity_out, addr_parity_oe, addr_parity_err_n, byte_lane_oe;
	logic data_oe, bad_par, cycle_strobe_n, cycle_strobe_dup_n, data_code;
	logic cache_out_n, owner_n, bus_want, dup;
	logic [1:0] func_sel_in, perfmon_evt, bus_core_ratio, perfmon_brkpt_shared;
	logic [3:0] debug_match_regs, brkpt_match, lat;
	logic [7:0] byte_lane_sel_in_n, byte_lane_sel_n;
	logic [7:0] byte_parity_in, byte_parity_out;
	logic [31:3] addr_in, addr_out;
	logic [63:0] rd_data, data_in, data_out, rdata;
	bus_pin_pkg::req_type req;
	bus_pin_pkg::mchk_type mchk_info;
	bus_pin_pkg::strap_type straps;
	int n_mismatch = 0;
	int n_tests = 0;
	bus_pin_logic dut_u (.*);
	bus_partner partner_u (.*);
	// Clock at 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(logic [63:0] got, logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test
	// Bounded poll; running out ends the run as a failure
	task automatic wait_for(ref logic s, input logic lvl);
		for (int i = 0; i < 40 && s !== lvl; i++)
			@(posedge clk) #1;
		if (s !== lvl) begin
			n_mismatch++;
			finish_test;
		end
	endtask : wait_for
	task automatic do_reset(logic role);
		proc_role_strap = role;
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		@(posedge clk) #1;
	endtask : do_reset
	// One whole cycle; ea is the address expected on the pins
	task automatic xfer(logic [31:3] a, logic wr, logic cab, logic [31:3] ea);
		req = '{a, 8'h0f, wr, 1'b1, cab, 64'h0123456789abcdef};
		req_valid = 1'b1;
		wait_for(cycle_strobe_n, 1'b0);
		req_valid = 1'b0;
		chk(addr_out, ea);
		chk(byte_lane_sel_n, 8'h0f);
		chk({data_code, cache_out_n, owner_n}, {1'b1, !cab, proc_role_strap});
		chk(cache_out_n, !cab);
		chk({bus_want, cycle_strobe_dup_n}, 2'b10);
		chk({addr_oe, addr_parity_oe, byte_lane_oe}, 3'b111);
		if (wr) begin
			wait_for(data_oe, 1'b1);
			chk(data_out, req.wdata);
		end
		wait_for(req_done, 1'b1);
		if (!wr) begin
			chk(rd_data, rdata);
			chk({rd_parity_err, rd_cache}, {bad_par, cab & !ext_cache_allow_n});
		end
	endtask : xfer
	task automatic t_pins;
		chk(straps, {1'b1, 4'ha, 2'h2, 1'b0});
		chk({bus_want, owner_n}, 2'b01);
		perfmon_evt = 2'h2;
		bus_core_ratio = 2'h1;
		repeat (2) @(posedge clk) #1;
		chk({perfmon_brkpt_shared, straps.ratio}, {2'h2, 2'h2});
		debug_match_regs = 4'h5;
		func_sel_in = 2'h3;
		func_sel_we = 1'b1;
		@(posedge clk) #1 func_sel_we = 1'b0;
		@(posedge clk) #1;
		chk({brkpt_match, perfmon_brkpt_shared}, {4'h5, 2'h1});
		$display("pins test ended");
	endtask : t_pins
	task automatic t_read;
		// Wrap mask only while the core is in real mode
		addr_wrap_mask_n = 1'b0;
		ext_cache_allow_n = 1'b0;
		xfer(29'h00020010, 1'b0, 1'b1, 29'h00000010);
		addr_wrap_mask_n = 1'b1;
		bad_par = 1'b1;
		lat = 4'h3;
		xfer(29'h00020010, 1'b0, 1'b0, 29'h00020010);
		bad_par = 1'b0;
		xfer(29'h00000100, 1'b1, 1'b1, 29'h00000100);
		$display("read write test ended");
	endtask : t_read
	// Abort in mid data phase, then address hold on the rerun
	task automatic t_abort;
		lat = 4'h6;
		fork
			xfer(29'h00000200, 1'b0, 1'b1, 29'h00000200);
			begin
				repeat (2) @(posedge clk) #1;
				bus_abort_n = 1'b0;
				@(posedge clk) #1 bus_abort_n = 1'b1;
				chk({addr_oe, data_oe}, 2'b00);
				wait_for(cycle_strobe_n, 1'b0);
				chk(addr_out, 29'h00000200);
				addr_float_req = 1'b1;
				@(posedge clk) #1 addr_float_req = 1'b0;
				chk({addr_oe, addr_parity_oe}, 2'b00);
			end
		join
		$display("abort test ended");
	endtask : t_abort
	task automatic t_snoop;
		addr_in = 29'h00001234;
		for (int b = 1; b >= 0; b--) begin
			addr_parity_in = ^addr_in[31:5] ^ b[0];
			snoop_addr_strobe_n = 1'b0;
			@(posedge clk) #1 snoop_addr_strobe_n = 1'b1;
			@(posedge clk) #1;
			chk(addr_parity_err_n, !b[0]);
			@(posedge clk) #1;
			chk(addr_parity_err_n, 1'b1);
		end
		$display("snoop test ended");
	endtask : t_snoop
	task automatic t_fail;
		for (int e = 1; e >= 0; e--) begin
			mchk_exc_enable = e[0];
			// No stop-clock request is held, so the fail is never lost
			cycle_fail_n = 1'b0;
			@(posedge clk) #1 cycle_fail_n = 1'b1;
			chk({mchk_exc, mchk_info},
				{e[0], req.addr, req.write, req.data_cyc});
		end
		$display("bus fail test ended");
	endtask : t_fail
	// Secondary role ignores the wrap mask and leaves owner_n high
	task automatic t_second;
		intc_bus_data1 = 1'b0;
		do_reset(1'b1);
		chk(straps, {1'b0, 4'ha, 2'h1, 1'b1});
		addr_wrap_mask_n = 1'b0;
		ext_cache_allow_n = 1'b1;
		dup = 1'b1;
		lat = 4'h0;
		xfer(29'h00020010, 1'b0, 1'b1, 29'h00020010);
		$display("secondary test ended");
	endtask : t_second
	// Main sequence; straps held stable through reset
	initial begin
		{req_valid, func_sel_we, mchk_exc_enable, addr_float_req, bad_par} = '0;
		dup = 1'b0;
		{addr_wrap_mask_n, bus_abort_n, cycle_fail_n} = '1;
		{ext_cache_allow_n, snoop_addr_strobe_n, addr_parity_in} = '1;
		{req, debug_match_regs, func_sel_in, perfmon_evt, addr_in, lat} = '0;
		intc_bus_data1 = 1'b1;
		byte_lane_sel_in_n = 8'h0a;
		bus_core_ratio = 2'h2;
		rdata = 64'hfedcba9876543210;
		do_reset(1'b0);
		t_pins;
		t_read;
		t_abort;
		t_snoop;
		t_fail;
		t_second;
		finish_test;
	end
endmodule : bus_pin_logic_bench
